// ==== common/ume_pkg.sv ====
// Constants, types and carriers shared by the mass-storage event dispatcher.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package ume_pkg;

    // ************************************************************
    // Register map, byte addresses on the Avalon-MM slave
    // ************************************************************
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_REQ_LO = 5'h08;
    localparam logic [4:0] ADDR_REQ_HI = 5'h0C;
    localparam logic [4:0] ADDR_CBW_TAG = 5'h10;
    localparam logic [4:0] ADDR_CBW_XLEN = 5'h14;
    localparam logic [4:0] ADDR_CBW_INFO = 5'h18;
    localparam int CTRL_RST_BUSY_BIT = 0;

    // ************************************************************
    // Flag codes and reset values
    // ************************************************************
    localparam logic [7:0] PWR_SUSPEND = 8'h00;
    localparam logic [7:0] PWR_RESUME = 8'h01;
    localparam logic [7:0] CBW_END = 8'h00;
    localparam logic [7:0] CBW_PROCESS = 8'h01;
    localparam logic [7:0] PWR_RESET = PWR_RESUME;
    localparam logic [7:0] CBW_BUSY_RESET = CBW_END;

    // ************************************************************
    // Packet layout
    // ************************************************************
    localparam int LEN_W = 7;
    localparam logic [LEN_W-1:0] CBW_BYTES = 7'h1F;
    localparam logic [4:0] CBW_LAST = 5'h1E;
    localparam logic [4:0] SETUP_LAST = 5'h07;
    localparam int CBW_TAG_POS = 4;
    localparam int CBW_XLEN_POS = 8;
    localparam int CBW_FLAGS_POS = 12;
    localparam int CBW_LUN_POS = 13;
    localparam int CBW_CBLEN_POS = 14;
    localparam int CBW_DIR_BIT = 7;
    localparam logic [1:0] REQ_STANDARD = 2'h0;
    localparam logic [1:0] REQ_CLASS = 2'h1;
    localparam logic [1:0] REQ_VENDOR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SUSP, ST_BRST, ST_AUTO, ST_SWREQ, ST_SETUP_RD, ST_REQ,
        ST_BULK, ST_CBW_RD, ST_CBW_ACC, ST_CBW_MARK, ST_CBW_CHK, ST_CMD_WAIT, ST_CSW_WAIT
    } ume_state_type;

    typedef enum logic [1:0] {
        CMD_ERROR, CMD_NO_DATA, CMD_DATA_IN, CMD_DATA_OUT
    } ume_cmd_type;

    // Event and status levels from the USB function controller
    typedef struct packed {
        logic main_usb_irq;
        logic resume_irq;
        logic suspend_resume_change;
        logic suspended_state_bit;
        logic bus_reset_event;
        logic auto_request_event;
        logic set_config_done;
        logic configured_status;
        logic sw_request_event;
        logic bulk_out_data_event;
    } ume_evt_type;

    // One-cycle source clear pulses toward the controller
    typedef struct packed {
        logic suspend_change_clear;
        logic bus_reset_clear;
        logic auto_request_clear;
        logic request_clear_bit;
        logic bulk_out_clear;
        logic clear_all;
    } ume_clr_type;

endpackage

// ==== dv/ume_ctl_model.sv ====
// Behavioural USB function controller facing the dispatcher.
// Assumes the bench loads mem, ptr and ev; sources drop on their clear pulse.
`timescale 1ns/1ps
module ume_ctl_model
(
    input wire logic clk_i,                   // System clock
    input wire logic fifo_rd_i,               // Pop one byte
    input wire ume_pkg::ume_clr_type clr_i,   // Source clear pulses
    input wire logic cmd_start_i,             // Command start
    input wire ume_pkg::ume_cmd_type kind_i,  // Command kind
    input wire logic csw_start_i,             // Status wrapper start
    output ume_pkg::ume_evt_type evt_o,       // Events and status
    output logic [7:0] fifo_data_o,           // FIFO head byte
    output logic cmd_done_o,                  // Command finished
    output logic csw_done_o                   // Status wrapper sent
);
    ume_pkg::ume_evt_type ev = '0;
    logic [7:0] mem [0:31];
    logic [4:0] ptr = '0;
    logic [3:0] cd = '0;
    logic [2:0] sd = '0;
    // A head byte not being popped is not held: show its inverse
    assign fifo_data_o = fifo_rd_i ? mem[ptr] : ~mem[ptr];
    assign cmd_done_o = cd[3];
    assign csw_done_o = sd[2];
    always_comb
    begin
        evt_o = ev;
        evt_o.main_usb_irq = ev.suspend_resume_change | ev.bus_reset_event | ev.auto_request_event
            | ev.sw_request_event | ev.bulk_out_data_event;
    end
    always @(posedge clk_i)
    begin
        if (fifo_rd_i) ptr <= ptr + 5'h01;
        cd <= {cd[2:0], cmd_start_i && kind_i != ume_pkg::CMD_ERROR};
        sd <= {sd[1:0], csw_start_i};
        if (clr_i.suspend_change_clear || clr_i.clear_all) ev.suspend_resume_change <= 1'b0;
        if (clr_i.bus_reset_clear || clr_i.clear_all) ev.bus_reset_event <= 1'b0;
        if (clr_i.auto_request_clear || clr_i.clear_all) ev.auto_request_event <= 1'b0;
        if (clr_i.request_clear_bit || clr_i.clear_all) ev.sw_request_event <= 1'b0;
        if (clr_i.bulk_out_clear || clr_i.clear_all) ev.bulk_out_data_event <= 1'b0;
    end
endmodule

// ==== dv/usb_msc_event_dispatcher_test.sv ====
// Self-checking bench for the dispatcher with a behavioural controller model.
// Assumes a 10 MHz clock; command kinds are checked from a queue of notes.
`timescale 1ns/1ps
module usb_msc_event_dispatcher_test;
    logic clk = 0, rst = 1, rd = 0, wr = 0, wq, frd, fsel, rqv, rqs, cst, cdn, sst, sdn, hlt, ien, fb, fe;
    logic [4:0] addr = '0;
    logic [31:0] wd = '0, rdata, q;
    logic [6:0] blen = '0;
    logic [7:0] fd;
    logic [1:0] rqt;
    logic [63:0] rqd;
    ume_pkg::ume_evt_type evt;
    ume_pkg::ume_clr_type clr;
    ume_pkg::ume_cmd_type kind;
    logic [1:0] expq [$];
    int errors = 0, n_checks = 0, nfb = 0, nfe = 0, nca = 0, nrv = 0, nst = 0, ncs = 0, i, t;
    int seed = 32'hd8cd_f643;
    ume_dispatcher DUT (.ref_clk_i(clk), .sys_rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wq),
        .evt_i(evt), .bulk_out_length_i(blen), .fifo_data_i(fd), .fifo_rd_o(frd), .fifo_sel_o(fsel),
        .clr_o(clr), .flush_bulk_o(fb), .flush_ep1_o(fe), .req_valid_o(rqv), .req_type_o(rqt),
        .req_stall_o(rqs), .req_data_o(rqd), .cmd_start_o(cst), .cmd_kind_o(kind), .cmd_done_i(cdn),
        .csw_start_o(sst), .csw_done_i(sdn), .halted_o(hlt), .irq_en_o(ien));
    ume_ctl_model P (.clk_i(clk), .fifo_rd_i(frd), .clr_i(clr), .cmd_start_i(cst), .kind_i(kind),
        .csw_start_i(sst), .evt_o(evt), .fifo_data_o(fd), .cmd_done_o(cdn), .csw_done_o(sdn));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Pulse counters and the queue comparison, sampled mid-cycle
    always @(negedge clk)
    begin
        nfb += fb; nfe += fe; nca += clr.clear_all; nrv += rqv; nst += rqs; ncs += sst;
        if (cst === 1'b1) chk(kind, expq.size() ? expq.pop_front() : 32'hffff_ffff);
    end
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        rd <= !w; wr <= w; addr <= a; wd <= d;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wq !== 1'b0 && k < 50);
        if (wq !== 1'b0) begin errors++; end_sim(); end
        q = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task settle;
        int k;
        @(posedge clk);
        for (k = 0; evt.main_usb_irq !== 1'b0; k++)
        begin
            if (k == 400) begin errors++; end_sim(); end
            @(posedge clk);
        end
        repeat (60) @(posedge clk);
    endtask
    function automatic logic [31:0] st(input logic [7:0] f, input logic b, input logic h, input logic e);
        return {12'h000, e, h, 1'b1, b, 8'h00, f};
    endfunction
    task cbw(input logic [6:0] n, input logic [7:0] cbl, input logic [7:0] fl, input logic [31:0] xl, input logic rb);
        for (i = 0; i < 32; i++) P.mem[i] = $random(seed);
        {P.mem[11], P.mem[10], P.mem[9], P.mem[8]} = xl;
        P.mem[12] = fl; P.mem[14] = cbl; P.ptr = 0;
        if (n == 7'h1f) expq.push_back(rb || cbl == 0 ? ume_pkg::CMD_ERROR : xl == 0 ? ume_pkg::CMD_NO_DATA
            : fl[7] ? ume_pkg::CMD_DATA_IN : ume_pkg::CMD_DATA_OUT);
        @(posedge clk);
        blen <= n; P.ev.bulk_out_data_event <= 1'b1;
        settle();
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0; P.ev.configured_status <= 1'b1;
        bus(0, ume_pkg::ADDR_STATUS, 0); chk(q, st(8'h01, 0, 0, 1));
        bus(0, 5'h1c, 0); chk(q, 32'h0);
        @(posedge clk) P.ev.bus_reset_event <= 1'b1;
        settle(); chk(nfb, 1);
        bus(0, ume_pkg::ADDR_STATUS, 0); chk(q, st(8'h01, 1, 0, 1));
        @(posedge clk) begin P.ev.auto_request_event <= 1'b1; P.ev.set_config_done <= 1'b1; end
        settle(); bus(0, ume_pkg::ADDR_STATUS, 0); chk(q, st(8'h01, 0, 0, 1));
        for (t = 0; t < 4; t++)
        begin
            for (i = 0; i < 8; i++) P.mem[i] = $random(seed);
            P.mem[0][6:5] = t; P.ptr = 0;
            @(posedge clk) P.ev.sw_request_event <= 1'b1;
            settle(); bus(0, ume_pkg::ADDR_REQ_LO, 0); chk(q, {P.mem[3], P.mem[2], P.mem[1], P.mem[0]});
            chk(rqd[63:32], {P.mem[7], P.mem[6], P.mem[5], P.mem[4]});
            chk(rqt, t);
        end
        chk(nrv, 3); chk(nst, 1);
        cbw(31, 0, 8'h80, 8, 0); bus(0, ume_pkg::ADDR_STATUS, 0); chk(q[15:8], 8'h01);
        cbw(31, 6, 8'h00, 0, 0); chk(nfe, 1);
        bus(0, ume_pkg::ADDR_STATUS, 0); chk(q[15:8], 8'h00);
        cbw(31, 10, 8'h80, 32'h200, 0); bus(0, ume_pkg::ADDR_CBW_XLEN, 0); chk(q, 32'h200);
        cbw(31, 10, 8'h00, 32'h40, 0);
        cbw(30, 10, 8'h00, 0, 0); chk(ncs, 3);
        bus(1, ume_pkg::ADDR_CTRL, 1); cbw(31, 10, 8'h00, 0, 1); bus(1, ume_pkg::ADDR_CTRL, 0);
        chk(ncs, 3); chk(expq.size(), 0);
        @(posedge clk) begin P.ev.suspended_state_bit <= 1'b1; P.ev.suspend_resume_change <= 1'b1; end
        @(posedge clk) P.ev.bus_reset_event <= 1'b1;
        settle(); chk(nca, 1); chk(nfb, 1); chk({hlt, ien}, 2'b10);
        bus(0, ume_pkg::ADDR_STATUS, 0); chk(q & 32'hffff_00ff, st(8'h00, 0, 1, 0));
        @(posedge clk) P.ev.resume_irq <= 1'b1;
        @(posedge clk) P.ev.resume_irq <= 1'b0;
        bus(0, ume_pkg::ADDR_STATUS, 0); chk(q & 32'hffff_00ff, st(8'h01, 0, 0, 1));
        chk({hlt, ien}, 2'b01);
        end_sim();
    end
endmodule

// ==== logic/ume_dispatcher.sv ====
// Event dispatcher and command-wrapper sorter behind a USB function controller.
// Assumes controller inputs are synchronous to ref_clk_i and FIFO head bytes
// are valid whenever fifo_rd_o pops them.
//
// Operation
// RQ1: Interrupt pass services control endpoint 0 and the bulk-OUT endpoint.
// RQ2: On suspend/resume change, pulse its clear, then judge suspend or resume.
// RQ3: Suspended and flag already suspend: end; else set suspend, clear all, end.
// RQ4: On bus reset, clear it, set bus reset seen, flush bulk FIFOs.
// RQ5: On auto request, clear it; config done by hardware clears bus reset seen.
// RQ6: Configured status is readable as the exact configured check.
// RQ7: On software request, clear it, read eight setup bytes, process request.
// RQ8: Classify request as standard, class or vendor and hand it on.
// RQ9: On bulk-OUT data, clear it and start wrapper reception.
// RQ10: Resume interrupt sets the power state flag to resume code.
// RQ11: Storage reset busy makes an arriving wrapper an error and stops.
// RQ12: Only a 31-byte count is read as a wrapper; others end reception.
// RQ13: Wrapper while busy flushes endpoint 1 FIFO and clears busy.
// RQ14: Then busy is set and the wrapper goes to command analysis.
// RQ15: Zero command-block length is a wrapper error.
// RQ16: Zero transfer length is a no-data command followed by status.
// RQ17: Direction bit 7 picks write or read path; status follows both.
// RQ18: Suspend code in the main flag disables interrupts and halts.
// RQ19: Resume interrupt leaves halt, sets resume code, enables interrupts.
// RQ20: Sources are checked in fixed order; a taken suspend stops the pass.

`timescale 1ns/1ps

module ume_dispatcher
(
    input wire logic ref_clk_i,                          // System clock, 10 MHz
    input wire logic sys_rst_i,                          // Synchronous reset, active high
    input wire logic [4:0] avs_address_i,                // Avalon byte address
    input wire logic avs_read_i,                         // Avalon read request
    input wire logic avs_write_i,                        // Avalon write request
    input wire logic [31:0] avs_writedata_i,             // Avalon write data
    output logic [31:0] avs_readdata_o,                  // Avalon read data
    output logic avs_waitrequest_o,                      // Avalon wait request
    input wire ume_pkg::ume_evt_type evt_i,              // Controller events and status
    input wire logic [ume_pkg::LEN_W-1:0] bulk_out_length_i, // Bytes waiting in bulk-OUT FIFO
    input wire logic [7:0] fifo_data_i,                  // Head byte of selected FIFO
    output logic fifo_rd_o,                              // Pop one byte
    output logic fifo_sel_o,                             // 0 control FIFO, 1 bulk-OUT FIFO
    output ume_pkg::ume_clr_type clr_o,                  // Source clear pulses
    output logic flush_bulk_o,                           // Flush bulk endpoint FIFOs
    output logic flush_ep1_o,                            // Flush endpoint 1 FIFO
    output logic req_valid_o,                            // Setup request ready, one cycle
    output logic [1:0] req_type_o,                       // Request class of req_valid_o
    output logic req_stall_o,                            // Reserved request type, stall
    output logic [63:0] req_data_o,                      // Setup packet, byte 0 in low bits
    output logic cmd_start_o,                            // Command start, one cycle
    output ume_pkg::ume_cmd_type cmd_kind_o,             // Kind of started command
    input wire logic cmd_done_i,                         // Command handler finished
    output logic csw_start_o,                            // Send status wrapper, one cycle
    input wire logic csw_done_i,                         // Status wrapper sent
    output logic halted_o,                               // Processor halted in suspend
    output logic irq_en_o                                // Interrupts enabled
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        ume_pkg::ume_state_type st;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] power_state_flag;
        logic bus_reset_seen_flag;
        logic [7:0] cbw_busy_flag;
        logic storage_reset_busy;
        logic halted;
        logic irq_en;
        logic [4:0] cnt;
        logic [7:0][7:0] setup;
        logic [30:0][7:0] cbw;
        ume_pkg::ume_clr_type clr;
        logic flush_bulk;
        logic flush_ep1;
        logic req_valid;
        logic [1:0] req_type;
        logic req_stall;
        logic cmd_start;
        ume_pkg::ume_cmd_type cmd_kind;
        logic csw_start;
    } ume_state_reg_type;

    ume_state_reg_type s_r;
    ume_state_reg_type s_nxt;

    function automatic logic [31:0] le_word(input logic [30:0][7:0] b, input int pos);
        le_word = {b[pos+3], b[pos+2], b[pos+1], b[pos]};
    endfunction

    logic [7:0] cb_len;
    logic [31:0] xfer_len;
    assign cb_len = s_r.cbw[ume_pkg::CBW_CBLEN_POS];
    assign xfer_len = le_word(s_r.cbw, ume_pkg::CBW_XLEN_POS);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.clr = '0;
        s_nxt.flush_bulk = 1'b0;
        s_nxt.flush_ep1 = 1'b0;
        s_nxt.req_valid = 1'b0;
        s_nxt.req_stall = 1'b0;
        s_nxt.cmd_start = 1'b0;
        s_nxt.csw_start = 1'b0;

        // Bus slave: one wait cycle, then the answer
        s_nxt.ack = (avs_read_i | avs_write_i) & ~s_r.ack;
        if (avs_read_i && !s_r.ack)
        begin
            if (avs_address_i == ume_pkg::ADDR_CTRL)
                s_nxt.rdata = {31'h0000_0000, s_r.storage_reset_busy};
            else if (avs_address_i == ume_pkg::ADDR_STATUS)
                s_nxt.rdata = {12'h000, s_r.irq_en, s_r.halted, evt_i.configured_status, // see RQ6
                               s_r.bus_reset_seen_flag, s_r.cbw_busy_flag, s_r.power_state_flag};
            else if (avs_address_i == ume_pkg::ADDR_REQ_LO)
                s_nxt.rdata = s_r.setup[3:0];
            else if (avs_address_i == ume_pkg::ADDR_REQ_HI)
                s_nxt.rdata = s_r.setup[7:4];
            else if (avs_address_i == ume_pkg::ADDR_CBW_TAG)
                s_nxt.rdata = le_word(s_r.cbw, ume_pkg::CBW_TAG_POS);
            else if (avs_address_i == ume_pkg::ADDR_CBW_XLEN)
                s_nxt.rdata = xfer_len;
            else if (avs_address_i == ume_pkg::ADDR_CBW_INFO)
                s_nxt.rdata = {8'h00, s_r.cbw[ume_pkg::CBW_FLAGS_POS], s_r.cbw[ume_pkg::CBW_LUN_POS], cb_len};
            else
                s_nxt.rdata = 32'h0000_0000;
        end
        if (avs_write_i && s_r.ack && avs_address_i == ume_pkg::ADDR_CTRL)
            s_nxt.storage_reset_busy = avs_writedata_i[ume_pkg::CTRL_RST_BUSY_BIT];

        case (s_r.st)
            ume_pkg::ST_IDLE:
            begin
                if (evt_i.resume_irq)
                begin
                    s_nxt.power_state_flag = ume_pkg::PWR_RESUME; // see RQ10
                    if (s_r.halted)
                    begin
                        s_nxt.halted = 1'b0; // see RQ19
                        s_nxt.irq_en = 1'b1; // see RQ19
                    end
                end
                else if (!s_r.halted && s_r.irq_en && s_r.power_state_flag == ume_pkg::PWR_SUSPEND)
                begin
                    s_nxt.irq_en = 1'b0; // see RQ18
                    s_nxt.halted = 1'b1; // see RQ18
                end
                else if (!s_r.halted && s_r.irq_en && evt_i.main_usb_irq)
                    s_nxt.st = ume_pkg::ST_SUSP; // see RQ1
            end
            ume_pkg::ST_SUSP:
            begin
                s_nxt.st = ume_pkg::ST_BRST; // see RQ20
                if (evt_i.suspend_resume_change)
                begin
                    s_nxt.clr.suspend_change_clear = 1'b1; // see RQ2
                    if (evt_i.suspended_state_bit)
                    begin
                        s_nxt.st = ume_pkg::ST_IDLE; // see RQ3
                        if (s_r.power_state_flag != ume_pkg::PWR_SUSPEND)
                        begin
                            s_nxt.power_state_flag = ume_pkg::PWR_SUSPEND; // see RQ3
                            s_nxt.clr.clear_all = 1'b1; // see RQ3
                        end
                    end
                end
            end
            ume_pkg::ST_BRST:
            begin
                s_nxt.st = ume_pkg::ST_AUTO;
                if (evt_i.bus_reset_event)
                begin
                    s_nxt.clr.bus_reset_clear = 1'b1; // see RQ4
                    s_nxt.bus_reset_seen_flag = 1'b1; // see RQ4
                    s_nxt.flush_bulk = 1'b1; // see RQ4
                end
            end
            ume_pkg::ST_AUTO:
            begin
                s_nxt.st = ume_pkg::ST_SWREQ;
                if (evt_i.auto_request_event)
                begin
                    s_nxt.clr.auto_request_clear = 1'b1; // see RQ5
                    if (evt_i.set_config_done)
                        s_nxt.bus_reset_seen_flag = 1'b0; // see RQ5
                end
            end
            ume_pkg::ST_SWREQ:
            begin
                s_nxt.st = ume_pkg::ST_BULK;
                s_nxt.cnt = 5'h00;
                if (evt_i.sw_request_event)
                begin
                    s_nxt.clr.request_clear_bit = 1'b1; // see RQ7
                    s_nxt.st = ume_pkg::ST_SETUP_RD; // see RQ7
                end
            end
            ume_pkg::ST_SETUP_RD:
            begin
                s_nxt.setup[s_r.cnt[2:0]] = fifo_data_i; // see RQ7
                s_nxt.cnt = s_r.cnt + 5'h01;
                if (s_r.cnt == ume_pkg::SETUP_LAST)
                    s_nxt.st = ume_pkg::ST_REQ;
            end
            ume_pkg::ST_REQ:
            begin
                s_nxt.req_type = s_r.setup[0][6:5]; // see RQ8
                if (s_r.setup[0][6:5] == 2'h3)
                    s_nxt.req_stall = 1'b1; // see RQ8
                else
                    s_nxt.req_valid = 1'b1; // see RQ8
                s_nxt.st = ume_pkg::ST_BULK;
            end
            ume_pkg::ST_BULK:
            begin
                s_nxt.st = ume_pkg::ST_IDLE;
                s_nxt.cnt = 5'h00;
                if (evt_i.bulk_out_data_event)
                begin
                    s_nxt.clr.bulk_out_clear = 1'b1; // see RQ9
                    if (s_r.storage_reset_busy)
                    begin
                        s_nxt.cmd_kind = ume_pkg::CMD_ERROR; // see RQ11
                        s_nxt.cmd_start = 1'b1; // see RQ11
                    end
                    else if (bulk_out_length_i == ume_pkg::CBW_BYTES)
                        s_nxt.st = ume_pkg::ST_CBW_RD; // see RQ12
                end
            end
            ume_pkg::ST_CBW_RD:
            begin
                s_nxt.cbw[s_r.cnt] = fifo_data_i;
                s_nxt.cnt = s_r.cnt + 5'h01;
                if (s_r.cnt == ume_pkg::CBW_LAST)
                    s_nxt.st = ume_pkg::ST_CBW_ACC;
            end
            ume_pkg::ST_CBW_ACC:
            begin
                if (s_r.cbw_busy_flag == ume_pkg::CBW_PROCESS)
                begin
                    s_nxt.flush_ep1 = 1'b1; // see RQ13
                    s_nxt.cbw_busy_flag = ume_pkg::CBW_END; // see RQ13
                end
                s_nxt.st = ume_pkg::ST_CBW_MARK;
            end
            ume_pkg::ST_CBW_MARK:
            begin
                s_nxt.cbw_busy_flag = ume_pkg::CBW_PROCESS; // see RQ14
                s_nxt.st = ume_pkg::ST_CBW_CHK;
            end
            ume_pkg::ST_CBW_CHK:
            begin
                s_nxt.cmd_start = 1'b1;
                s_nxt.st = ume_pkg::ST_CMD_WAIT;
                if (cb_len == 8'h00)
                begin
                    s_nxt.cmd_kind = ume_pkg::CMD_ERROR; // see RQ15
                    s_nxt.st = ume_pkg::ST_IDLE; // see RQ15
                end
                else if (xfer_len == 32'h0000_0000)
                    s_nxt.cmd_kind = ume_pkg::CMD_NO_DATA; // see RQ16
                else if (s_r.cbw[ume_pkg::CBW_FLAGS_POS][ume_pkg::CBW_DIR_BIT])
                    s_nxt.cmd_kind = ume_pkg::CMD_DATA_IN; // see RQ17
                else
                    s_nxt.cmd_kind = ume_pkg::CMD_DATA_OUT; // see RQ17
            end
            ume_pkg::ST_CMD_WAIT:
            begin
                if (cmd_done_i)
                begin
                    s_nxt.csw_start = 1'b1; // see RQ16
                    s_nxt.st = ume_pkg::ST_CSW_WAIT;
                end
            end
            ume_pkg::ST_CSW_WAIT:
            begin
                if (csw_done_i)
                begin
                    s_nxt.cbw_busy_flag = ume_pkg::CBW_END;
                    s_nxt.st = ume_pkg::ST_IDLE;
                end
            end
            default:
                s_nxt.st = ume_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            s_r <= '0;
            s_r.st <= ume_pkg::ST_IDLE;
            s_r.power_state_flag <= ume_pkg::PWR_RESET;
            s_r.cbw_busy_flag <= ume_pkg::CBW_BUSY_RESET;
            s_r.irq_en <= 1'b1;
            s_r.cmd_kind <= ume_pkg::CMD_ERROR;
        end
        else
            s_r <= s_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign avs_readdata_o = s_r.rdata;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_r.ack;
    assign fifo_rd_o = (s_r.st == ume_pkg::ST_SETUP_RD) || (s_r.st == ume_pkg::ST_CBW_RD);
    assign fifo_sel_o = (s_r.st == ume_pkg::ST_CBW_RD);
    assign clr_o = s_r.clr;
    assign flush_bulk_o = s_r.flush_bulk;
    assign flush_ep1_o = s_r.flush_ep1;
    assign req_valid_o = s_r.req_valid;
    assign req_type_o = s_r.req_type;
    assign req_stall_o = s_r.req_stall;
    assign req_data_o = s_r.setup;
    assign cmd_start_o = s_r.cmd_start;
    assign cmd_kind_o = s_r.cmd_kind;
    assign csw_start_o = s_r.csw_start;
    assign halted_o = s_r.halted;
    assign irq_en_o = s_r.irq_en;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence setup_read_seq;
        fifo_rd_o && !fifo_sel_o [*8] ##1 s_r.st == ume_pkg::ST_REQ;
    endsequence

    sequence cbw_accept_seq;
        s_r.st == ume_pkg::ST_CBW_MARK ##1 s_r.cbw_busy_flag == ume_pkg::CBW_PROCESS;
    endsequence

    a_susp_clear: assert property (s_r.st == ume_pkg::ST_SUSP && evt_i.suspend_resume_change // see RQ2
        |=> clr_o.suspend_change_clear) else $error("suspend change not cleared");
    a_susp_enter: assert property (s_r.st == ume_pkg::ST_SUSP && evt_i.suspend_resume_change // see RQ3
        && evt_i.suspended_state_bit && s_r.power_state_flag != ume_pkg::PWR_SUSPEND
        |=> clr_o.clear_all && s_r.power_state_flag == ume_pkg::PWR_SUSPEND && s_r.st == ume_pkg::ST_IDLE)
        else $error("suspend entry wrong");
    a_busrst_flush: assert property (s_r.st == ume_pkg::ST_BRST && evt_i.bus_reset_event // see RQ4
        |=> flush_bulk_o && s_r.bus_reset_seen_flag && clr_o.bus_reset_clear) else $error("bus reset missed");
    a_auto_config: assert property (s_r.st == ume_pkg::ST_AUTO && evt_i.auto_request_event // see RQ5
        && evt_i.set_config_done |=> !s_r.bus_reset_seen_flag && clr_o.auto_request_clear)
        else $error("auto config not handled");
    a_setup_read: assert property (s_r.st == ume_pkg::ST_SWREQ && evt_i.sw_request_event // see RQ7
        |=> clr_o.request_clear_bit ##0 setup_read_seq) else $error("setup read wrong");
    a_req_sort: assert property (s_r.st == ume_pkg::ST_REQ // see RQ8
        |=> (req_valid_o ^ req_stall_o) && req_type_o == $past(s_r.setup[0][6:5])) else $error("request not sorted");
    a_bulk_length: assert property (s_r.st == ume_pkg::ST_BULK && evt_i.bulk_out_data_event // see RQ12
        && !s_r.storage_reset_busy && bulk_out_length_i != ume_pkg::CBW_BYTES
        |=> s_r.st == ume_pkg::ST_IDLE && !fifo_rd_o) else $error("bad length accepted");
    a_reset_busy: assert property (s_r.st == ume_pkg::ST_BULK && evt_i.bulk_out_data_event // see RQ11
        && s_r.storage_reset_busy |=> cmd_start_o && cmd_kind_o == ume_pkg::CMD_ERROR && !fifo_rd_o)
        else $error("storage reset not honoured");
    a_cbw_busy: assert property (s_r.st == ume_pkg::ST_CBW_ACC // see RQ14
        |=> cbw_accept_seq) else $error("busy flag not set");
    a_no_cmd: assert property (s_r.st == ume_pkg::ST_CBW_CHK && cb_len == 8'h00 // see RQ15
        |=> cmd_start_o && cmd_kind_o == ume_pkg::CMD_ERROR && s_r.st == ume_pkg::ST_IDLE)
        else $error("empty command accepted");
    a_halt_enter: assert property (s_r.st == ume_pkg::ST_IDLE && !s_r.halted && s_r.irq_en // see RQ18
        && s_r.power_state_flag == ume_pkg::PWR_SUSPEND && !evt_i.resume_irq
        |=> halted_o && !irq_en_o) else $error("halt not entered");
    a_halt_leave: assert property (s_r.st == ume_pkg::ST_IDLE && s_r.halted && evt_i.resume_irq // see RQ19
        |=> !halted_o && irq_en_o && s_r.power_state_flag == ume_pkg::PWR_RESUME) else $error("resume failed");

endmodule
